// *** logic/lcd_twowire_params.svh ***
// constants for the two-wire display slave port
`ifndef LCD_TWOWIRE_PARAMS_SVH
`define LCD_TWOWIRE_PARAMS_SVH
`define ADDR_HI_BITS     5'h0F
`define BLANK_CHAR       8'h20
`define RAM_DEPTH        80
`define RAM_AW           7
`define RAM_LAST         7'h4F
`define FN_SET_MASK      8'hE0
`define FN_SET_CODE      8'h20
`define FN_DL_BIT        4
`define FN_N_BIT         3
`define FN_F_BIT         2
`define DISP_MASK        8'hF8
`define DISP_CODE        8'h08
`define ENTRY_MASK       8'hFC
`define ENTRY_CODE       8'h04
`define DDADDR_BIT       7
`define CLEAR_CODE       8'h01
`define HOME_MASK        8'hFE
`define HOME_CODE        8'h02
`define CTRL_CONT_BIT    7
`define CTRL_SEL_BIT     6
`define BIT_LAST         3'h7
`define DISP_D_BIT       2
`define DISP_C_BIT       1
`define DISP_B_BIT       0
`define ENTRY_ID_BIT     1
`define ENTRY_S_BIT      0
// 8-bit bus, one line, 5x8, all off, increment, no shift
`define CFG_RESET        8'h82
`endif

// *** logic/lcd_twowire_pkg.sv ***
// types shared by the two-wire display slave port
package lcd_twowire_pkg;
   typedef struct packed {
      logic       bus_width_bit;
      logic       two_line;
      logic       font_tall;
      logic       display_on;
      logic       cursor_on;
      logic       blink_on;
      logic       entry_inc;
      logic       entry_shift;
   } cfg_t;
   typedef struct packed {
      logic       cmd_data_select;
      logic [7:0] data;
   } word_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_CTRL, ST_DATA, ST_IGNORE
   } phase_t;
endpackage

// *** logic/lcd_twowire_slave.sv ***
// two-wire write-only slave port of a character display controller
//
// Contract
// RL1: host sets bus width bit to one
// RL2: host keeps data stable while clock high
// RL3: data fall with clock high starts transfer
// RL4: data rise with clock high ends transfer
// RL5: host starts only when bus idle
// RL6: eight data bits then acknowledge slot
// RL7: acknowledge every byte by pulling data low
// RL8: on master nack release data line
// RL9: answer only addresses 0111100 to 0111111
// RL10: two low address bits from straps
// RL11: matching slaves ack; others ignore transfer
// RL12: parse control byte then data byte
// RL13: cleared continuation bit means data until stop
// RL14: select one writes ram, pointer steps
// RL15: select zero decodes bytes as instructions
// RL16: host ends each transmission with stop
// RL17: power-on init runs, busy held high
// RL18: init fills display ram with 20H
// RL19: init sets eight-bit, one line, 5x8
// RL20: init clears display, cursor and blink
// RL21: init sets increment, no display shift
// RL22: host initializes if internal reset fails
// RL23: bus width bit selects eight or four bits
// RL24: ram write steps pointer by entry direction
// RL25: data line only driven low, open drain
`include "lcd_twowire_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lcd_twowire_slave
   import lcd_twowire_pkg::*;
#(
   parameter int RAM_WORDS = `RAM_DEPTH
) (
   input  wire logic       CLK_SYS,
   input  wire logic       SYS_RST,
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_N,
   input  wire logic       ADDR_STRAP_LO,
   input  wire logic       ADDR_STRAP_HI,
   output logic            BUSY_INDICATION,
   output logic            BUS_WIDTH_BIT,
   output logic            TWO_LINE,
   output logic            FONT_TALL,
   output logic            DISPLAY_ON,
   output logic            CURSOR_ON,
   output logic            BLINK_ON,
   output logic            ENTRY_INC,
   output logic            ENTRY_SHIFT,
   output logic [`RAM_AW-1:0] RAM_POINTER,
   input  wire logic [`RAM_AW-1:0] RAM_RD_ADDR,
   output logic [7:0]      RAM_RD_DATA
);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // step the pointer, wrapping inside the ram
   function automatic logic [`RAM_AW-1:0] step_ptr(input logic [`RAM_AW-1:0] p, input logic inc);
      if (inc) begin
         step_ptr = (p == `RAM_LAST) ? '0 : p + 1'b1;
      end else begin
         step_ptr = (p == '0) ? `RAM_LAST : p - 1'b1;
      end
   endfunction

   // -------------------------------------------------------------
   // line sampling and bus conditions
   // -------------------------------------------------------------
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= SCL_IN;
         sda_d <= SDA_IN;
      end
   end

   // edges and control conditions
   always_comb begin
      scl_rise   = SCL_IN && !scl_d;
      scl_fall   = !SCL_IN && scl_d;
      start_cond = SCL_IN && scl_d && sda_d && !SDA_IN; // [RL3]
      stop_cond  = SCL_IN && scl_d && !sda_d && SDA_IN; // [RL4]
   end

   // -------------------------------------------------------------
   // byte receiver
   // -------------------------------------------------------------
   phase_t     phase;
   phase_t     next_phase;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic       ack_slot;
   logic       next_ack_slot;
   logic       bit_seen;
   logic       next_bit_seen;
   logic       ack_drive;
   logic       next_ack_drive;
   logic       sel;
   logic       next_sel;
   logic       push_valid;
   logic       next_push_valid;
   word_t      push_word;
   word_t      next_push_word;
   logic       buf_in_ready;
   logic [6:0] own_addr;

   assign own_addr = {`ADDR_HI_BITS, ADDR_STRAP_HI, ADDR_STRAP_LO}; // [RL9] [RL10]

   // phase sequencing, shifting and acknowledge control
   always_comb begin
      next_phase      = phase;
      next_bit_cnt    = bit_cnt;
      next_shreg      = shreg;
      next_ack_slot   = ack_slot;
      next_bit_seen   = bit_seen;
      next_ack_drive  = ack_drive;
      next_sel        = sel;
      next_push_valid = push_valid && !buf_in_ready;
      next_push_word  = push_word;
      if (start_cond) begin
         next_phase     = ST_ADDR; // [RL3]
         next_bit_cnt   = '0;
         next_bit_seen  = 1'b0; // the start's own clock fall carries no bit
         next_ack_slot  = 1'b0;
         next_ack_drive = 1'b0;
      end else if (stop_cond) begin
         next_phase     = ST_IDLE; // [RL4]
         next_ack_slot  = 1'b0;
         next_ack_drive = 1'b0;
      end else if (phase != ST_IDLE && phase != ST_IGNORE) begin
         if (scl_rise && !ack_slot) begin
            next_shreg    = {shreg[6:0], SDA_IN};
            next_bit_seen = 1'b1;
         end
         // count a fall only when a rise carried a bit before it
         if (scl_fall && !ack_slot && bit_seen) begin
            next_bit_seen = 1'b0; // [RL6]
            if (bit_cnt == `BIT_LAST) begin
               next_ack_slot = 1'b1; // [RL6]
               next_bit_cnt  = '0;
               unique case (phase)
                  ST_ADDR: begin
                     // only write addresses that match are answered
                     if (shreg[7:1] == own_addr && !shreg[0]) begin
                        next_ack_drive = 1'b1; // [RL7] [RL11]
                        next_phase     = ST_CTRL;
                     end else begin
                        next_phase = ST_IGNORE; // [RL11]
                     end
                  end
                  ST_CTRL: begin
                     next_ack_drive = 1'b1; // [RL7] [RL12]
                     next_sel       = shreg[`CTRL_SEL_BIT];
                     next_phase     = ST_DATA; // [RL13]
                  end
                  ST_DATA: begin
                     next_ack_drive  = 1'b1; // [RL7]
                     next_push_valid = 1'b1;
                     next_push_word  = '{cmd_data_select: sel, data: shreg};
                  end
                  default: begin
                     next_phase = ST_IGNORE;
                  end
               endcase
            end else begin
               next_bit_cnt = bit_cnt + 1'b1;
            end
         end else if (scl_fall && ack_slot) begin
            // release after the acknowledge pulse
            next_ack_slot  = 1'b0;
            next_ack_drive = 1'b0; // [RL8]
         end
      end
   end

   // continuation tracking: after a continued control byte one data byte follows
   logic cont;
   logic next_cont;
   always_comb begin
      next_cont = cont;
      if (start_cond) begin
         next_cont = 1'b0;
      end else if (phase == ST_CTRL && scl_fall && !ack_slot && bit_cnt == `BIT_LAST) begin
         next_cont = shreg[`CTRL_CONT_BIT];
      end
   end

   phase_t phase_fix;
   always_comb begin
      phase_fix = next_phase;
      // a continued command word returns to a control byte after its data byte
      if (phase == ST_DATA && cont && scl_fall && !ack_slot && bit_cnt == `BIT_LAST) begin
         phase_fix = ST_CTRL; // [RL12]
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         phase      <= ST_IDLE;
         bit_cnt    <= '0;
         shreg      <= '0;
         ack_slot   <= 1'b0;
         bit_seen   <= 1'b0;
         ack_drive  <= 1'b0;
         sel        <= 1'b0;
         push_valid <= 1'b0;
         push_word  <= '0;
         cont       <= 1'b0;
      end else begin
         phase      <= phase_fix;
         bit_cnt    <= next_bit_cnt;
         shreg      <= next_shreg;
         ack_slot   <= next_ack_slot;
         bit_seen   <= next_bit_seen;
         ack_drive  <= next_ack_drive;
         sel        <= next_sel;
         push_valid <= next_push_valid;
         push_word  <= next_push_word;
         cont       <= next_cont;
      end
   end

   // open drain: output held low, enable low only while acknowledging
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         SDA_OUT  <= 1'b0;
         SDA_OE_N <= 1'b1;
      end else begin
         SDA_OUT  <= 1'b0;               // [RL25]
         SDA_OE_N <= ~next_ack_drive;    // [RL7] [RL25]
      end
   end

   // -------------------------------------------------------------
   // word buffer between receiver and executor
   // -------------------------------------------------------------
   logic  exec_valid;
   logic  exec_ready;
   word_t exec_word;

   word_buffer #(.DEPTH(2)) u_buf (
      .clk       (CLK_SYS),
      .rst       (SYS_RST),
      .in_valid  (push_valid),
      .in_ready  (buf_in_ready),
      .in_word   (push_word),
      .out_valid (exec_valid),
      .out_ready (exec_ready),
      .out_word  (exec_word)
   );

   // -------------------------------------------------------------
   // executor: init, instructions, ram writes
   // -------------------------------------------------------------
   logic [7:0]         ram [RAM_WORDS];
   cfg_t               cfg;
   cfg_t               next_cfg;
   logic [`RAM_AW-1:0] ptr;
   logic [`RAM_AW-1:0] next_ptr;
   logic               busy;
   logic               next_busy;
   logic [`RAM_AW-1:0] fill;
   logic [`RAM_AW-1:0] next_fill;
   logic               ram_we;
   logic [`RAM_AW-1:0] ram_wa;
   logic [7:0]         ram_wd;
   logic [7:0]         d;

   assign exec_ready = !busy;

   // instruction decode and fill sequencing
   always_comb begin
      next_cfg  = cfg;
      next_ptr  = ptr;
      next_busy = busy;
      next_fill = fill;
      ram_we    = 1'b0;
      ram_wa    = ptr;
      ram_wd    = `BLANK_CHAR;
      d         = exec_word.data;
      if (busy) begin
         ram_we = 1'b1; // [RL17] [RL18]
         ram_wa = fill;
         if (fill == `RAM_LAST) begin
            next_busy = 1'b0;
            next_fill = '0;
            next_ptr  = '0;
         end else begin
            next_fill = fill + 1'b1;
         end
      end else if (exec_valid) begin
         if (exec_word.cmd_data_select) begin
            ram_we   = 1'b1; // [RL14]
            ram_wd   = d;
            next_ptr = step_ptr(ptr, cfg.entry_inc); // [RL24]
         end else if (d[`DDADDR_BIT]) begin
            next_ptr = (d[`RAM_AW-1:0] > `RAM_LAST) ? '0 : d[`RAM_AW-1:0]; // [RL15]
         end else if ((d & `FN_SET_MASK) == `FN_SET_CODE) begin
            next_cfg.bus_width_bit = d[`FN_DL_BIT]; // [RL15] [RL23]
            next_cfg.two_line      = d[`FN_N_BIT];
            next_cfg.font_tall     = d[`FN_F_BIT];
         end else if ((d & `DISP_MASK) == `DISP_CODE) begin
            next_cfg.display_on = d[`DISP_D_BIT]; // [RL15]
            next_cfg.cursor_on  = d[`DISP_C_BIT];
            next_cfg.blink_on   = d[`DISP_B_BIT];
         end else if ((d & `ENTRY_MASK) == `ENTRY_CODE) begin
            next_cfg.entry_inc   = d[`ENTRY_ID_BIT]; // [RL15]
            next_cfg.entry_shift = d[`ENTRY_S_BIT];
         end else if ((d & `HOME_MASK) == `HOME_CODE) begin
            next_ptr = '0;
         end else if (d == `CLEAR_CODE) begin
            next_busy = 1'b1; // clear reuses the blank fill
            next_fill = '0;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         busy <= 1'b1; // [RL17]
         fill <= '0;
         ptr  <= '0;
         // 8-bit bus, one line, 5x8, all off, increment, no shift
         cfg  <= `CFG_RESET; // [RL19] [RL20] [RL21]
      end else begin
         busy <= next_busy;
         fill <= next_fill;
         ptr  <= next_ptr;
         cfg  <= next_cfg;
      end
      if (ram_we) begin
         ram[ram_wa] <= ram_wd;
      end
   end

   // registered status outputs
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         BUSY_INDICATION <= 1'b1;
         {BUS_WIDTH_BIT, TWO_LINE, FONT_TALL, DISPLAY_ON, CURSOR_ON, BLINK_ON, ENTRY_INC, ENTRY_SHIFT} <= `CFG_RESET;
         RAM_POINTER     <= '0;
         RAM_RD_DATA     <= 8'h00;
      end else begin
         BUSY_INDICATION <= next_busy;
         {BUS_WIDTH_BIT, TWO_LINE, FONT_TALL, DISPLAY_ON, CURSOR_ON, BLINK_ON, ENTRY_INC, ENTRY_SHIFT} <= next_cfg;
         RAM_POINTER     <= next_ptr;
         RAM_RD_DATA     <= (RAM_RD_ADDR > `RAM_LAST) ? 8'h00 : ram[RAM_RD_ADDR];
      end
   end
endmodule
`default_nettype wire

// *** logic/word_buffer.sv ***
// two-entry valid/ready buffer for received words
`timescale 1ns/1ps
`default_nettype none
module word_buffer
   import lcd_twowire_pkg::*;
#(
   parameter int DEPTH = 2
) (
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  in_valid,
   output logic       in_ready,
   input  wire word_t in_word,
   output logic       out_valid,
   input  wire logic  out_ready,
   output word_t      out_word
);
   word_t      mem [DEPTH];
   logic [1:0] count;
   logic       wr_ptr;
   logic       rd_ptr;
   logic [1:0] next_count;
   logic       next_wr_ptr;
   logic       next_rd_ptr;
   logic       push;
   logic       pop;

   // handshake and pointer update
   always_comb begin
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? ~wr_ptr : wr_ptr;
      next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
      next_count  = count + 2'(push) - 2'(pop);
   end

   assign in_ready  = (count != 2'(DEPTH));
   assign out_valid = (count != 2'h0);
   assign out_word  = mem[rd_ptr];

   // storage and pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         count  <= 2'h0;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
      end else begin
         count  <= next_count;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
      if (push) begin
         mem[wr_ptr] <= in_word;
      end
   end
endmodule
`default_nettype wire

// *** test/lcd_twowire_checker.sv ***
// assertions on the two-wire display slave port
`timescale 1ns/1ps
`default_nettype none
module lcd_twowire_checker
   import lcd_twowire_pkg::*;
#(
   parameter int RAM_WORDS = 80
) (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic SCL_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE_N,
   input wire logic BUSY_INDICATION,
   input wire cfg_t CFG
);
   // ----------------------------------------
   // ack and power-on checks
   // ----------------------------------------
   localparam int BUSY_MAX = 400;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   sequence ack_high;
      !SDA_OE_N && SCL_IN;
   endsequence
   sequence ack_end;
      ack_high ##1 !SCL_IN;
   endsequence
   AST_OPEN_DRAIN: assert property (!SDA_OE_N |-> !SDA_OUT)
      else $error("data line driven high");
   AST_RESET_QUIET: assert property (disable iff (1'b0) SYS_RST |=> SDA_OE_N && BUSY_INDICATION)
      else $error("reset left line driven or not busy");
   AST_FUNC_INIT: assert property ($fell(SYS_RST) |-> CFG[7:5] == 3'b100)
      else $error("function defaults wrong");
   AST_DISP_INIT: assert property ($fell(SYS_RST) |-> CFG[4:2] == 3'b000)
      else $error("display defaults wrong");
   AST_ENTRY_INIT: assert property ($fell(SYS_RST) |-> CFG[1:0] == 2'b10)
      else $error("entry defaults wrong");
   AST_BUSY_HOLD: assert property ($fell(SYS_RST) |-> BUSY_INDICATION [*8])
      else $error("busy dropped early");
   AST_BUSY_ENDS: assert property ($fell(SYS_RST) |-> ##[1:BUSY_MAX] !BUSY_INDICATION)
      else $error("busy never dropped");
   AST_ACK_CLK_LOW: assert property ($fell(SDA_OE_N) |-> !SCL_IN)
      else $error("ack started with clock high");
   AST_ACK_STANDS: assert property (ack_high |=> !SDA_OE_N || !SCL_IN)
      else $error("ack released during clock high");
   AST_ACK_RELEASE: assert property (ack_end |-> ##[0:8] SDA_OE_N)
      else $error("data line not released after ack");
endmodule
bind lcd_twowire_slave lcd_twowire_checker #(.RAM_WORDS(RAM_WORDS)) lcd_twowire_checker_i (
   .CLK_SYS         (CLK_SYS),
   .SYS_RST         (SYS_RST),
   .SCL_IN          (SCL_IN),
   .SDA_OUT         (SDA_OUT),
   .SDA_OE_N        (SDA_OE_N),
   .BUSY_INDICATION (BUSY_INDICATION),
   .CFG             ({BUS_WIDTH_BIT, TWO_LINE, FONT_TALL, DISPLAY_ON, CURSOR_ON, BLINK_ON, ENTRY_INC, ENTRY_SHIFT})
);
`default_nettype wire

// *** test/test_lcd_ctrl_twowire_slave_port.sv ***
// self-checking bench for the two-wire display slave port
`include "lcd_twowire_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_lcd_ctrl_twowire_slave_port
   import lcd_twowire_pkg::*;
;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic        clk_sys;
   logic        sys_rst;
   logic        strap_lo;
   logic        strap_hi;
   logic [6:0]  rd_addr;
   logic        scl;
   logic        h_oe_n;
   logic        sda_out;
   logic        sda_oe_n;
   logic        busy;
   wire cfg_t   cfg;
   logic [6:0]  ptr;
   logic [7:0]  rd_data;
   logic [7:0]  tx[$];
   logic        ack_q[$];
   logic [31:0] seed;
   logic [6:0]  my;
   logic [7:0]  d1;
   int          bitcnt;
   int          fails;
   int          tests_run;
   // pull-up wire resolved from both open-drain drivers
   wire sda_w = !h_oe_n ? 1'b0 : (!sda_oe_n ? sda_out : 1'b1);
   lcd_twowire_slave lcd_twowire_slave_i (
      .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda_w),
      .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDR_STRAP_LO(strap_lo), .ADDR_STRAP_HI(strap_hi),
      .BUSY_INDICATION(busy), .BUS_WIDTH_BIT(cfg.bus_width_bit), .TWO_LINE(cfg.two_line),
      .FONT_TALL(cfg.font_tall), .DISPLAY_ON(cfg.display_on), .CURSOR_ON(cfg.cursor_on),
      .BLINK_ON(cfg.blink_on), .ENTRY_INC(cfg.entry_inc), .ENTRY_SHIFT(cfg.entry_shift),
      .RAM_POINTER(ptr), .RAM_RD_ADDR(rd_addr), .RAM_RD_DATA(rd_data)
   );
   twowire_host twowire_host_i (.clk(clk_sys), .scl(scl), .sda_oe_n(h_oe_n));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one frame: address byte then the queued bytes, each ack noted
   task automatic send(input logic [7:0] a, input logic ok);
      twowire_host_i.start();
      ack_q.push_back(ok);
      twowire_host_i.put_byte(a);
      foreach (tx[i]) begin
         ack_q.push_back(ok);
         twowire_host_i.put_byte(tx[i]);
      end
      twowire_host_i.stop();
      tx.delete();
   endtask
   task automatic read_ram(input logic [6:0] a, input logic [7:0] exp);
      rd_addr = a;
      repeat (2) @(negedge clk_sys);
      check("ram", exp, rd_data);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 400) begin
         check("busy", 8'h00, {7'h00, busy});
         print_verdict();
      end
   endtask
   // ack monitor: start clears the count, ninth rising clock compares
   always @(negedge sda_w) if (scl) bitcnt = 0;
   always @(posedge scl) begin
      bitcnt++;
      if (bitcnt == 9) begin
         bitcnt = 0;
         if (ack_q.size() > 0) check("ack", {7'h00, ack_q.pop_front()}, {7'h00, !sda_w});
      end
   end
   // ----------------------------------------
   // clock and main sequence
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      sys_rst = 1'b1;
      strap_lo = 1'b0;
      strap_hi = 1'b0;
      rd_addr = 7'h00;
      seed = 32'hA764;
      bitcnt = 0;
      fails = 0;
      tests_run = 0;
      repeat (12) @(negedge clk_sys);
      sys_rst = 1'b0;
      check("busy", 8'h01, {7'h00, busy});
      check("config", 8'h82, cfg);
      wait_idle();
      for (int a = 0; a < 80; a++) read_ram(a[6:0], `BLANK_CHAR);
      $display("test power-on done");
      for (int k = 0; k < 8; k++) begin
         {strap_hi, strap_lo} = k[1:0];
         seed = lfsr(seed);
         send({`ADDR_HI_BITS, seed[1:0], 1'b0}, seed[1:0] == k[1:0]);
      end
      send({`ADDR_HI_BITS, 2'b11, 1'b1}, 1'b0);
      $display("test addressing done");
      my = {`ADDR_HI_BITS, 2'b11};
      seed = lfsr(seed);
      d1 = seed[7:0];
      tx = '{8'h80, 8'h85, 8'hC0, 8'h41, 8'h40, d1, 8'h43};
      send({my, 1'b0}, 1'b1);
      check("pointer", 8'h08, {1'b0, ptr});
      read_ram(7'h05, 8'h41);
      read_ram(7'h06, d1);
      read_ram(7'h07, 8'h43);
      $display("test ram write done");
      tx = '{8'h00, 8'h3C, 8'h0F, 8'h04};
      send({my, 1'b0}, 1'b1);
      check("config", 8'hFC, cfg);
      tx = '{8'h40, 8'h55};
      send({my, 1'b0}, 1'b1);
      read_ram(7'h08, 8'h55);
      check("pointer", 8'h07, {1'b0, ptr});
      $display("test instructions done");
      tx = '{8'h40, 8'h99};
      send({7'h3B, 1'b0}, 1'b0);
      check("pointer", 8'h07, {1'b0, ptr});
      read_ram(7'h07, 8'h43);
      $display("test foreign address done");
      // home from pointer 7, then set pointer and clear: refill and pointer back to 0
      tx = '{8'h00, 8'h02};
      send({my, 1'b0}, 1'b1);
      check("pointer", 8'h00, {1'b0, ptr});
      tx = '{8'h00, 8'h86, 8'h01};
      send({my, 1'b0}, 1'b1);
      wait_idle();
      check("pointer", 8'h00, {1'b0, ptr});
      read_ram(7'h07, `BLANK_CHAR);
      read_ram(7'h08, `BLANK_CHAR);
      $display("test home and clear done");
      check("ack queue", 8'h00, 8'(ack_q.size()));
      print_verdict();
   end
endmodule
`default_nettype wire

// *** test/twowire_host.sv ***
// bus master model that writes frames to the slave port
`timescale 1ns/1ps
`default_nettype none
module twowire_host (
   input  wire logic clk,
   output logic      scl,
   output logic      sda_oe_n
);
   // ----------------------------------------
   // bit timing and frame tasks
   // ----------------------------------------
   int half = 6;
   // idle bus: both lines released high
   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
   end
   task automatic wait_half();
      repeat (half) @(negedge clk);
   endtask
   // data falls while clock high, only from idle
   task automatic start();
      wait_half();
      sda_oe_n = 1'b0;
      wait_half();
      scl = 1'b0;
   endtask
   // data rises while clock high to close the frame
   task automatic stop();
      sda_oe_n = 1'b0;
      wait_half();
      scl = 1'b1;
      wait_half();
      sda_oe_n = 1'b1;
      wait_half();
   endtask
   // msb first, data changes only with clock low, ninth pulse for ack
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sda_oe_n = b[i];
         wait_half();
         scl = 1'b1;
         wait_half();
         scl = 1'b0;
      end
      sda_oe_n = 1'b1;
      wait_half();
      scl = 1'b1;
      wait_half();
      scl = 1'b0;
   endtask
endmodule
`default_nettype wire
